// ---- design/shunt_monitor_config_regs.sv ----
// Purpose: setup and shunt result registers behind a two-wire serial slave
// Assumes: SCL and SDA_IN already synchronous to REF_CLK; SCL slow
//          against REF_CLK
// Notes:   SHUNT_SAMPLE is the converter value in 10 uV steps
`timescale 1ns/10ps
`default_nettype none
module shunt_monitor_config_regs
	import shunt_monitor_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR      = DEV_ADDR_DEF,
	parameter int unsigned CYCLES_PER_US = CYCLES_PER_US_DEF
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RESETN,
	// two-wire serial bus
	input  wire logic        SCL,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	// converter
	input  wire logic [15:0] SHUNT_SAMPLE,
	output logic             SHUNT_CONV_ACTIVE,
	output logic             BUS_CONV_ACTIVE,
	// setup fields
	output logic             BUS_RANGE_SELECT,
	output logic [1:0]       SHUNT_GAIN_SELECT,
	output logic [3:0]       BUS_ADC_SETTING,
	output logic [3:0]       SHUNT_ADC_SETTING,
	output logic [2:0]       OP_MODE
);
	bus_state_t  bstate, next_bstate;
	logic [2:0]  bit_cnt, next_bit_cnt;
	logic [7:0]  shreg, next_shreg;
	logic [7:0]  ptr, next_ptr;
	logic [15:0] wbuf, next_wbuf;
	logic [15:0] tx, next_tx;
	logic        is_read, next_is_read;
	logic        byte_hi, next_byte_hi;
	logic        sda_oe, next_sda_oe;
	logic        scl_q, next_scl_q;
	logic        sda_q, next_sda_q;
	logic        scl_rise, scl_fall, start_c, stop_c;
	logic        wr_done;
	logic [15:0] wr_data;
	logic [7:0]  cur_byte;

	conv_state_t cstate, next_cstate;
	logic [31:0] cnt, next_cnt;
	logic [15:0] setup, next_setup;
	logic [15:0] result, next_result;
	logic [15:0] pend_val, next_pend_val;
	logic [9:0]  upd_cnt, next_upd_cnt;
	logic        pend, next_pend;
	logic        armed, next_armed;
	logic        sh_act, next_sh_act;
	logic        bus_act, next_bus_act;
	logic        commit;

	function automatic logic [31:0] conv_cycles(input logic [3:0] s);
		return 32'(conv_time_us(s) * CYCLES_PER_US);
	endfunction

	function automatic logic [15:0] read_reg(input logic [7:0] p,
		input logic [15:0] s, input logic [15:0] r);
		if (p == PTR_SETUP) begin
			return s;
		end else if (p == PTR_SHUNT) begin
			return r;
		end
		return 16'h0000;
	endfunction

	// saturate to the gain's full scale; sign fills the unused top bits
	function automatic logic [15:0] clamp_shunt(input logic [15:0] raw,
		input logic [1:0] g);
		logic signed [16:0] fs;
		logic signed [16:0] nfs;
		logic signed [16:0] v;
		fs  = $signed({1'b0, SHUNT_FS_X1 << g});
		nfs = -fs;
		v   = $signed({raw[15], raw});
		if (v > fs) begin
			return fs[15:0];
		end else if (v < nfs) begin
			return nfs[15:0];
		end
		return raw;
	endfunction

	assign scl_rise = SCL & ~scl_q;
	assign scl_fall = ~SCL & scl_q;
	assign start_c  = SCL & scl_q & sda_q & ~SDA_IN;
	assign stop_c   = SCL & scl_q & ~sda_q & SDA_IN;
	assign cur_byte = {shreg[6:0], SDA_IN};
	assign wr_data  = {wbuf[15:8], cur_byte};

	// serial slave: sample on SCL rise, drive on SCL fall
	always_comb begin
		next_bstate  = bstate;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_ptr     = ptr;
		next_wbuf    = wbuf;
		next_tx      = tx;
		next_is_read = is_read;
		next_byte_hi = byte_hi;
		next_sda_oe  = sda_oe;
		next_scl_q   = SCL;
		next_sda_q   = SDA_IN;
		wr_done      = 1'b0;
		if (start_c) begin
			next_bstate  = B_ADDR;
			next_bit_cnt = 3'h0;
			next_sda_oe  = 1'b0;
		end else if (stop_c) begin
			next_bstate = B_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			next_shreg   = cur_byte;
			next_bit_cnt = bit_cnt + 3'h1;
			case (bstate)
				B_IDLE: begin
					next_bit_cnt = 3'h0;
				end
				B_ADDR: begin
					if (bit_cnt == 3'h7) begin
						if (cur_byte[7:1] == DEV_ADDR) begin
							next_bstate  = B_ADDR_ACK;
							next_is_read = cur_byte[0];
						end else begin
							next_bstate = B_IDLE;
						end
					end
				end
				B_ADDR_ACK: begin
					next_bit_cnt = 3'h0;
					next_byte_hi = 1'b1;
					if (is_read) begin
						next_bstate = B_RDATA;
						next_tx     = read_reg(ptr, setup, result);
					end else begin
						next_bstate = B_PTR;
					end
				end
				B_PTR: begin
					if (bit_cnt == 3'h7) begin
						next_ptr    = cur_byte;
						next_bstate = B_PTR_ACK;
					end
				end
				B_PTR_ACK: begin
					next_bit_cnt = 3'h0;
					next_byte_hi = 1'b1;
					next_bstate  = B_WDATA;
				end
				B_WDATA: begin
					if (bit_cnt == 3'h7) begin
						next_bstate = B_WDATA_ACK;
						if (byte_hi) begin
							next_wbuf[15:8] = cur_byte;
						end else begin
							next_wbuf[7:0] = cur_byte;
							wr_done = (ptr == PTR_SETUP);
						end
					end
				end
				B_WDATA_ACK: begin
					next_bit_cnt = 3'h0;
					next_byte_hi = ~byte_hi;
					next_bstate  = B_WDATA;
				end
				B_RDATA: begin
					next_tx = {tx[14:0], 1'b0};
					if (bit_cnt == 3'h7) begin
						next_bstate = B_RDATA_ACK;
					end
				end
				B_RDATA_ACK: begin
					next_bit_cnt = 3'h0;
					if (!SDA_IN) begin
						next_bstate  = B_RDATA;
						next_byte_hi = ~byte_hi;
						if (!byte_hi) begin
							next_tx = read_reg(ptr, setup, result);
						end
					end else begin
						next_bstate = B_IDLE;
					end
				end
				default: begin
					next_bstate = B_IDLE;
				end
			endcase
		end else if (scl_fall) begin
			case (bstate)
				B_ADDR_ACK, B_PTR_ACK, B_WDATA_ACK: next_sda_oe = 1'b1;
				B_RDATA: next_sda_oe = ~tx[15];
				default: next_sda_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			bstate  <= B_IDLE;
			bit_cnt <= 3'h0;
			shreg   <= 8'h00;
			ptr     <= 8'h00;
			wbuf    <= 16'h0000;
			tx      <= 16'h0000;
			is_read <= 1'b0;
			byte_hi <= 1'b1;
			sda_oe  <= 1'b0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else begin
			bstate  <= next_bstate;
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			ptr     <= next_ptr;
			wbuf    <= next_wbuf;
			tx      <= next_tx;
			is_read <= next_is_read;
			byte_hi <= next_byte_hi;
			sda_oe  <= next_sda_oe;
			scl_q   <= next_scl_q;
			sda_q   <= next_sda_q;
		end
	end

	// delayed commit of setup writes, then conversion sequencing
	always_comb begin
		next_cstate   = cstate;
		next_cnt      = cnt;
		next_setup    = setup;
		next_result   = result;
		next_pend     = pend;
		next_pend_val = pend_val;
		next_upd_cnt  = upd_cnt;
		next_armed    = armed;
		next_sh_act   = sh_act;
		next_bus_act  = bus_act;
		commit        = 1'b0;
		if (wr_done) begin
			next_pend     = 1'b1;
			next_pend_val = wr_data;
			next_upd_cnt  = 10'(UPDATE_CYCLES - 1);
		end else if (pend) begin
			if (upd_cnt == 10'h000) begin
				commit = 1'b1;
			end else begin
				next_upd_cnt = upd_cnt - 10'h001;
			end
		end
		if (commit) begin
			next_pend    = 1'b0;
			next_cstate  = C_IDLE;
			next_sh_act  = 1'b0;
			next_bus_act = 1'b0;
			next_armed   = 1'b1;
			if (pend_val[RST_BIT]) begin
				next_setup  = SETUP_RESET;
				next_result = SHUNT_RESET;
			end else begin
				next_setup = pend_val & SETUP_STORE_MASK;
			end
		end else begin
			case (cstate)
				C_IDLE: begin
					next_armed = 1'b0;
					if ((armed || setup[MODE_CONT_BIT]) &&
						setup[MODE_BUS_BIT:MODE_SHUNT_BIT] != 2'h0) begin
						if (setup[MODE_SHUNT_BIT]) begin
							next_cstate = C_SHUNT;
							next_sh_act = 1'b1;
							next_cnt    = conv_cycles(SHUNT_ADC_SETTING) -
								32'h0000_0001;
						end else begin
							next_cstate  = C_BUS;
							next_bus_act = 1'b1;
							next_cnt     = conv_cycles(BUS_ADC_SETTING) -
								32'h0000_0001;
						end
					end
				end
				C_SHUNT: begin
					if (cnt == 32'h0000_0000) begin
						next_result = clamp_shunt(SHUNT_SAMPLE,
							setup[GAIN_HI:GAIN_LO]);
						next_sh_act = 1'b0;
						if (setup[MODE_BUS_BIT]) begin
							next_cstate  = C_BUS;
							next_bus_act = 1'b1;
							next_cnt     = conv_cycles(BUS_ADC_SETTING) -
								32'h0000_0001;
						end else begin
							next_cstate = C_IDLE;
						end
					end else begin
						next_cnt = cnt - 32'h0000_0001;
					end
				end
				C_BUS: begin
					if (cnt == 32'h0000_0000) begin
						next_bus_act = 1'b0;
						next_cstate  = C_IDLE;
					end else begin
						next_cnt = cnt - 32'h0000_0001;
					end
				end
				default: begin
					next_cstate = C_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cstate   <= C_IDLE;
			cnt      <= 32'h0000_0000;
			setup    <= SETUP_RESET;
			result   <= SHUNT_RESET;
			pend     <= 1'b0;
			pend_val <= 16'h0000;
			upd_cnt  <= 10'h000;
			armed    <= 1'b0;
			sh_act   <= 1'b0;
			bus_act  <= 1'b0;
		end else begin
			cstate   <= next_cstate;
			cnt      <= next_cnt;
			setup    <= next_setup;
			result   <= next_result;
			pend     <= next_pend;
			pend_val <= next_pend_val;
			upd_cnt  <= next_upd_cnt;
			armed    <= next_armed;
			sh_act   <= next_sh_act;
			bus_act  <= next_bus_act;
		end
	end

	assign SDA_OUT           = 1'b0;
	assign SDA_OE            = sda_oe;
	assign SHUNT_CONV_ACTIVE = sh_act;
	assign BUS_CONV_ACTIVE   = bus_act;
	assign BUS_RANGE_SELECT  = setup[RANGE_BIT];
	assign SHUNT_GAIN_SELECT = setup[GAIN_HI:GAIN_LO];
	assign BUS_ADC_SETTING   = setup[BUS_ADC_HI:BUS_ADC_LO];
	assign SHUNT_ADC_SETTING = setup[SHUNT_ADC_HI:SHUNT_ADC_LO];
	assign OP_MODE           = setup[MODE_HI:0];

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);

	sequence wr_seen;
		wr_done ##1 pend[*8];
	endsequence
	sequence shunt_entry;
		cstate != C_SHUNT ##1 cstate == C_SHUNT;
	endsequence
	sequence bus_entry;
		cstate != C_BUS ##1 cstate == C_BUS;
	endsequence
	sequence shunt_done;
		cstate == C_SHUNT && cnt == 32'h0000_0000 && !commit;
	endsequence

	self_clear_a: assert property (commit && pend_val[RST_BIT] |=>
		setup == SETUP_RESET && result == SHUNT_RESET && !setup[RST_BIT])
		else $error("reset bit did not restore defaults");
	range_bit_a: assert property (commit && !pend_val[RST_BIT] |=>
		BUS_RANGE_SELECT == $past(pend_val[RANGE_BIT]) &&
		SHUNT_GAIN_SELECT == $past(pend_val[GAIN_HI:GAIN_LO]))
		else $error("range or gain not taken from write");
	write_delay_a: assert property (wr_seen |-> ##[490:492] commit)
		else $error("setup write not committed after 4 us");
	shunt_time_a: assert property (shunt_entry |->
		cnt == conv_cycles(SHUNT_ADC_SETTING) - 32'h0000_0001)
		else $error("shunt conversion length wrong");
	bus_time_a: assert property (bus_entry |->
		cnt == conv_cycles(BUS_ADC_SETTING) - 32'h0000_0001)
		else $error("bus conversion length wrong");
	shunt_result_a: assert property (shunt_done |=>
		result == clamp_shunt($past(SHUNT_SAMPLE), SHUNT_GAIN_SELECT))
		else $error("shunt result not latched");
	sign_bits_a: assert property (shunt_done |=>
		(($signed(result) >>> (SIGN_SHIFT_BASE + SHUNT_GAIN_SELECT)) == 0) ||
		(($signed(result) >>> (SIGN_SHIFT_BASE + SHUNT_GAIN_SELECT)) == -1))
		else $error("sign bits disagree");
	full_scale_a: assert property (shunt_done |=>
		$signed({result[15], result}) <=
			$signed({1'b0, SHUNT_FS_X1 << SHUNT_GAIN_SELECT}) &&
		$signed({result[15], result}) >=
			-$signed({1'b0, SHUNT_FS_X1 << SHUNT_GAIN_SELECT}))
		else $error("shunt result beyond full scale");
	trig_start_a: assert property (cstate == C_IDLE ##1 cstate != C_IDLE |->
		$past(armed) || setup[MODE_CONT_BIT])
		else $error("conversion started without trigger");
	mode_off_a: assert property (cstate == C_IDLE && OP_MODE[1:0] == 2'h0 |=>
		cstate == C_IDLE)
		else $error("conversion started while off");
	ack_drive_a: assert property (bstate == B_ADDR_ACK && scl_fall |=>
		SDA_OE)
		else $error("address not acknowledged");
endmodule
`default_nettype wire

// ---- design/shunt_monitor_pkg.sv ----
// Purpose: shared constants and types of the shunt monitor register block
// Assumes: 125 MHz reference clock
// Notes:   conversion times are held in microseconds
`default_nettype none
package shunt_monitor_pkg;
	localparam int          CLK_PERIOD_NS     = 8;
	localparam int          UPDATE_DELAY_NS   = 4000;
	localparam int          UPDATE_CYCLES     =
		(UPDATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CYCLES_PER_US_DEF = 1000 / CLK_PERIOD_NS;
	// arbitrary default bus address
	localparam logic [6:0]  DEV_ADDR_DEF      = 7'h40;
	localparam logic [7:0]  PTR_SETUP         = 8'h00;
	localparam logic [7:0]  PTR_SHUNT         = 8'h01;
	localparam logic [15:0] SETUP_RESET       = 16'h399f;
	localparam logic [15:0] SHUNT_RESET       = 16'h0000;
	localparam logic [15:0] SETUP_STORE_MASK  = 16'h3fff;
	localparam logic [15:0] SHUNT_FS_X1       = 16'h0fa0;
	localparam int          RST_BIT           = 15;
	localparam int          RANGE_BIT         = 13;
	localparam int          GAIN_HI           = 12;
	localparam int          GAIN_LO           = 11;
	localparam int          BUS_ADC_HI        = 10;
	localparam int          BUS_ADC_LO        = 7;
	localparam int          SHUNT_ADC_HI      = 6;
	localparam int          SHUNT_ADC_LO      = 3;
	localparam int          MODE_HI           = 2;
	localparam int          MODE_SHUNT_BIT    = 0;
	localparam int          MODE_BUS_BIT      = 1;
	localparam int          MODE_CONT_BIT     = 2;
	localparam int          SIGN_SHIFT_BASE   = 12;

	typedef enum logic [3:0] {
		B_IDLE, B_ADDR, B_ADDR_ACK, B_PTR, B_PTR_ACK,
		B_WDATA, B_WDATA_ACK, B_RDATA, B_RDATA_ACK
	} bus_state_t;

	typedef enum logic [1:0] {C_IDLE, C_SHUNT, C_BUS} conv_state_t;

	// conversion time in microseconds for an adc setting
	function automatic logic [31:0] conv_time_us(input logic [3:0] s);
		logic [31:0] t;
		t = 32'h0000_0054;
		if (!s[3]) begin
			case (s[1:0])
				2'h0: t = 32'h0000_0054;
				2'h1: t = 32'h0000_0094;
				2'h2: t = 32'h0000_0114;
				default: t = 32'h0000_0214;
			endcase
		end else begin
			case (s[2:0])
				3'h0: t = 32'h0000_0214;
				3'h1: t = 32'h0000_0424;
				3'h2: t = 32'h0000_0852;
				3'h3: t = 32'h0000_10a4;
				3'h4: t = 32'h0000_213e;
				3'h5: t = 32'h0000_427c;
				3'h6: t = 32'h0000_8502;
				default: t = 32'h0001_0a04;
			endcase
		end
		return t;
	endfunction
endpackage
`default_nettype wire

// ---- sim/i2c_host_model.sv ----
// Purpose: bus host model that drives the two-wire serial bus
// Assumes: open drain data line with pull-up, resolved in the bench
// Notes:   signals change on falling REF_CLK edges only
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
	parameter int HALF = 2
) (
	// clock
	input  wire logic REF_CLK,
	// bus
	input  wire logic sda_line,
	output var logic  scl,
	output var logic  sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold();
		repeat (HALF) @(negedge REF_CLK);
	endtask
	// data set in the low phase, line sampled at end of high phase
	task automatic put_bit(input logic b, output logic seen);
		hold();
		sda_low = ~b;
		hold();
		scl = 1'b1;
		hold();
		seen = sda_line;
		scl = 1'b0;
	endtask
	task automatic start();
		hold();
		sda_low = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sda_low = 1'b1;
		hold();
		scl = 1'b0;
	endtask
	task automatic stop();
		hold();
		sda_low = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sda_low = 1'b0;
		hold();
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) put_bit(d[i], s);
		put_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv_byte(output logic [7:0] d, input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			d[i] = s;
		end
		put_bit(last, s);
	endtask
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
			input logic [15:0] v, output logic ack);
		logic k0, k1, k2, k3;
		start();
		send_byte({a, 1'b0}, k0);
		send_byte(p, k1);
		send_byte(v[15:8], k2);
		send_byte(v[7:0], k3);
		stop();
		ack = k0 & k1 & k2 & k3;
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
			output logic [15:0] v, output logic ack);
		logic k0, k1, k2;
		start();
		send_byte({a, 1'b0}, k0);
		send_byte(p, k1);
		start();
		send_byte({a, 1'b1}, k2);
		recv_byte(v[15:8], 1'b0);
		recv_byte(v[7:0], 1'b1);
		stop();
		ack = k0 & k1 & k2;
	endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the setup and shunt result registers
// Assumes: conversions shortened with CYCLES_PER_US of 1
// Notes:   inputs change on falling REF_CLK edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import shunt_monitor_pkg::*;
	typedef struct packed {
		logic [15:0] wr;
		logic [15:0] smp;
		logic [15:0] res;
		logic [1:0]  act;
	} row_t;
	logic        ref_clk, resetn, scl, host_low, oe, sda_out, sda_line;
	logic        shunt_act, bus_act, rng;
	logic [1:0]  gain;
	logic [2:0]  mode;
	logic [3:0]  bus_adc, shunt_adc;
	logic [15:0] sample;
	int          mismatches, total_checks;
	row_t        rows [10] = '{
		'{16'h1805, 16'h7d02, 16'h7d00, 2'h2},
		'{16'h3001, 16'hc17f, 16'hc180, 2'h0},
		'{16'h0803, 16'h1f41, 16'h1f40, 2'h0},
		'{16'h0001, 16'hf05f, 16'hf060, 2'h0},
		'{16'h4782, 16'h0100, 16'hf060, 2'h1},
		'{16'h0078, 16'h0100, 16'hf060, 2'h0},
		'{16'h0004, 16'h0100, 16'hf060, 2'h0},
		'{16'h0006, 16'h0100, 16'hf060, 2'h1},
		'{16'h0007, 16'hffff, 16'hffff, 2'h2},
		'{16'h1005, 16'h3e81, 16'h3e80, 2'h2}};

	assign sda_line = ~(host_low | (oe & ~sda_out));

	shunt_monitor_config_regs #(.CYCLES_PER_US(1)) dut (
		.REF_CLK(ref_clk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda_line),
		.SDA_OUT(sda_out), .SDA_OE(oe), .SHUNT_SAMPLE(sample),
		.SHUNT_CONV_ACTIVE(shunt_act), .BUS_CONV_ACTIVE(bus_act),
		.BUS_RANGE_SELECT(rng), .SHUNT_GAIN_SELECT(gain),
		.BUS_ADC_SETTING(bus_adc), .SHUNT_ADC_SETTING(shunt_adc),
		.OP_MODE(mode));
	i2c_host_model host (.REF_CLK(ref_clk), .sda_line(sda_line),
		.scl(scl), .sda_low(host_low));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cmp_word(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [15:0] fields();
		return {2'b00, rng, gain, bus_adc, shunt_adc, mode};
	endfunction
	task automatic wr(input logic [6:0] a, input logic [15:0] v,
			input logic [15:0] ack_exp);
		logic k;
		host.write_reg(a, 8'h00, v, k);
		cmp_word("write ack", ack_exp, {15'h0000, k});
	endtask
	task automatic rd(input string what, input logic [7:0] p,
			input logic [15:0] exp);
		logic [15:0] v;
		logic        k;
		host.read_reg(DEV_ADDR_DEF, p, v, k);
		cmp_word(what, exp, v);
	endtask

	initial begin
		resetn = 1'b0;
		sample = 16'h0000;
		repeat (6) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (3) @(negedge ref_clk);
		cmp_word("reset fields", 16'h399f, fields());
		cmp_word("reset activity", 16'h0002, {14'h0000, shunt_act, bus_act});
		rd("reset setup", 8'h00, 16'h399f);
		rd("reset shunt", 8'h01, 16'h0000);
		$display("test reset done");
		foreach (rows[i]) begin
			sample = rows[i].smp;
			wr(DEV_ADDR_DEF, rows[i].wr, 16'h0001);
			// commit delay plus one short conversion pair
			repeat (700) @(negedge ref_clk);
			cmp_word("fields", rows[i].wr & SETUP_STORE_MASK, fields());
			cmp_word("activity", {14'h0000, rows[i].act},
				{14'h0000, shunt_act, bus_act});
			rd("setup", 8'h00, rows[i].wr & SETUP_STORE_MASK);
			rd("shunt", 8'h01, rows[i].res);
			$display("test row %0d done", i);
		end
		// read back before the commit delay sees the old value
		wr(DEV_ADDR_DEF, 16'h0abc, 16'h0001);
		cmp_word("early fields", 16'h1005, fields());
		rd("early setup", 8'h00, 16'h1005);
		repeat (500) @(negedge ref_clk);
		rd("late setup", 8'h00, 16'h0abc);
		$display("test commit delay done");
		// read shunt before the restarted conversion can end
		wr(DEV_ADDR_DEF, 16'h8000, 16'h0001);
		repeat (510) @(negedge ref_clk);
		rd("reset bit shunt", 8'h01, 16'h0000);
		rd("reset bit setup", 8'h00, 16'h399f);
		cmp_word("reset bit fields", 16'h399f, fields());
		$display("test soft reset done");
		wr(7'h41, 16'h0000, 16'h0000);
		repeat (600) @(negedge ref_clk);
		cmp_word("foreign fields", 16'h399f, fields());
		rd("unmapped", 8'h05, 16'h0000);
		$display("test refusals done");
		tally_and_finish();
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		$display("[FAIL] watchdog expected finish seen timeout");
		tally_and_finish();
	end
endmodule
`default_nettype wire
